//--- rtl/acs_pkg.sv
// Package: register map, field layout, reset values and timing for the conversion sequencer
package acs_pkg;

  // ***********************************************************
  // Register map (byte addresses on APB)
  // ***********************************************************
  localparam logic [11:0] ACS_OFF_SEQ_CTRL = 12'h000;  // adc_sequence_control
  localparam logic [11:0] ACS_OFF_REF_BUF = 12'h004;   // adc_reference_buffer_status
  localparam logic [11:0] ACS_OFF_CHAN_SEL = 12'h008;  // group_channel_select
  localparam logic [11:0] ACS_OFF_RESULT = 12'h00C;    // Result read port, pops the buffer

  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int ACS_POS_POWER = 0;       // converter_power_on
  localparam int ACS_POS_START = 1;       // Start / completion
  localparam int ACS_POS_PATTERN = 2;     // sequence_pattern, two bits
  localparam int ACS_POS_MULTI = 4;       // multi_group_select
  localparam int ACS_POS_LOOP = 5;        // loop_mode_select
  localparam int ACS_POS_PTR = 0;         // buffer_read_pointer, two bits
  localparam int ACS_POS_OVERRUN = 2;     // result_buffer_overrun
  localparam int ACS_POS_EMPTY = 3;       // result_buffer_empty
  localparam int ACS_POS_BUF_EN = 4;      // result_buffer_enable
  localparam int ACS_POS_REF = 6;         // reference_source_select, two bits

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic [7:0] ACS_RST_SEQ_CTRL = 8'h00;
  localparam logic [1:0] ACS_RST_REF = 2'h0;
  localparam logic [7:0] ACS_RST_CHAN_SEL = 8'h00;

  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam int ACS_CLK_MHZ = 250;                 // pclk rate
  localparam int ACS_POWERUP_NS = 1000;             // Power-up settling time
  localparam int ACS_POWERUP_CYC = (ACS_POWERUP_NS * ACS_CLK_MHZ + 999) / 1000;

  // Sizes
  localparam int ACS_RES_W = 10;                    // Result width
  localparam int ACS_BUF_DEPTH = 4;                 // Result buffer words

  // Request to the analog core: one or two groups sampled at once
  typedef struct packed {
    logic       dual;       // Sample both S/H inputs together
    logic [1:0] group_a;    // First group (S/H-1 for pairs)
    logic [1:0] group_b;    // Second group (S/H-2 for pairs)
    logic [7:0] chan_sel;   // Channel inside each group
    logic [1:0] ref_sel;    // Reference choice
  } acs_conv_req_type;

  // Answer from the analog core
  typedef struct packed {
    logic                 done;     // One-cycle pulse: results valid
    logic [ACS_RES_W-1:0] res_a;    // Result of first group
    logic [ACS_RES_W-1:0] res_b;    // Result of second group
  } acs_conv_rsp_type;

endpackage

//--- rtl/acs_sequencer.sv
// Sequencer: APB registers, auto-conversion sequencing and result buffer
//
// Functional notes
// - Each conversion yields a 10-bit result
// - Four-word buffer holds unread results
// - Bit 5 selects continuous loop
// - Bit 4 selects multi-channel operation
// - Multi 00: A then B
// - Multi 01: A, B, C, D
// - Multi 10: A and B together
// - Multi 11: AB pair, then CD pair
// - Single: field picks group A-D
// - Start bit or trigger begins cycle
// - Single-shot clears start bit when finished
// - Loop repeats until software clears start
// - Power bit, delay, then sampling
// - Bits 7-6 select references
// - Bit 4 enables the result buffer
// - Empty flag when nothing unread
// - Overrun flag on unread overwrite
// - Unimplemented bits read zero
// - Pointer names next location read
// - Channel-select register picks input per group
`default_nettype none
module acs_sequencer #(
  parameter int POWERUP_CYC = acs_pkg::ACS_POWERUP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic trigger_in,
  output acs_pkg::acs_conv_req_type conv_req,
  output logic conv_start,
  input wire acs_pkg::acs_conv_rsp_type conv_rsp,
  output logic converter_power_on
);
  import acs_pkg::*;

  // ***********************************************************
  // Declarations
  // ***********************************************************
  typedef enum {ST_OFF, ST_WARM, ST_IDLE, ST_ISSUE, ST_WAIT} acs_state_type;
  acs_state_type state_q;                     // Sequencer state
  logic power_q;                              // converter_power_on
  logic start_q;                              // Start / completion bit
  logic [1:0] pattern_q;                      // sequence_pattern
  logic multi_q;                              // multi_group_select
  logic loop_q;                               // loop_mode_select
  logic [1:0] ref_q;                          // reference_source_select
  logic buf_en_q;                             // result_buffer_enable
  logic [7:0] chan_q;                         // group_channel_select
  logic overrun_q;                            // result_buffer_overrun
  logic [1:0] step_q;                         // Step in the current set
  logic [15:0] warm_q;                        // Power-up counter
  logic [ACS_RES_W-1:0] buf_q [ACS_BUF_DEPTH]; // Result words
  logic [ACS_BUF_DEPTH-1:0] unread_q;         // One flag per location
  logic [1:0] wptr_q;                         // Next location written
  logic [1:0] rptr_q;                         // buffer_read_pointer
  logic trig_s1_q;                            // Trigger synchroniser stage 1
  logic trig_s2_q;                            // Trigger synchroniser stage 2
  logic trig_s3_q;                            // Previous stage-2 value for edge
  logic wr_en;                                // APB write access
  logic rd_en;                                // APB read access
  logic trig_rise;                            // Trigger edge
  logic sw_start;                             // Software writes start = 1
  logic sw_stop;                              // Software writes start = 0
  logic last_step;                            // Current step ends the set
  logic [1:0] n_steps;                        // Steps in set minus one
  logic [1:0] grp_a;                          // First group of this step
  logic [1:0] grp_b;                          // Second group of this step
  logic dual;                                 // Pair sampling
  logic push_a;                               // Write first result
  logic push_b;                               // Write second result
  logic pop;                                  // Software reads result port
  logic [1:0] wptr_b;                         // Location of second result

  // ***********************************************************
  // APB decode
  // ***********************************************************
  // Zero-wait slave: every access completes in its first access cycle
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign sw_start = wr_en && paddr == ACS_OFF_SEQ_CTRL && pstrb[0] && pwdata[ACS_POS_START];
  assign sw_stop = wr_en && paddr == ACS_OFF_SEQ_CTRL && pstrb[0] && !pwdata[ACS_POS_START];
  assign pop = rd_en && paddr == ACS_OFF_RESULT;

  // Ready and error answer in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(paddr == ACS_OFF_SEQ_CTRL || paddr == ACS_OFF_REF_BUF ||
                 paddr == ACS_OFF_CHAN_SEL || paddr == ACS_OFF_RESULT);
    end
  end

  // Read data registered on the setup cycle so it is stable in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        ACS_OFF_SEQ_CTRL: begin
          // Bits 7-6 stay zero
          prdata <= {26'h0, loop_q, multi_q, pattern_q, start_q, power_q};
        end
        ACS_OFF_REF_BUF: begin
          // Bit 5 stays zero; flags show live state
          prdata <= {24'h0, ref_q, 1'b0, buf_en_q, ~|unread_q, overrun_q, rptr_q};
        end
        ACS_OFF_CHAN_SEL: begin
          prdata <= {24'h0, chan_q};
        end
        ACS_OFF_RESULT: begin
          prdata <= {22'h0, buf_q[rptr_q]};
        end
        default: begin
          prdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ***********************************************************
  // Control registers
  // ***********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_q <= ACS_RST_SEQ_CTRL[ACS_POS_POWER];
      pattern_q <= ACS_RST_SEQ_CTRL[ACS_POS_PATTERN +: 2];
      multi_q <= ACS_RST_SEQ_CTRL[ACS_POS_MULTI];
      loop_q <= ACS_RST_SEQ_CTRL[ACS_POS_LOOP];
      ref_q <= ACS_RST_REF;
      buf_en_q <= 1'b0;
      chan_q <= ACS_RST_CHAN_SEL;
    end else if (wr_en && pstrb[0]) begin
      if (paddr == ACS_OFF_SEQ_CTRL) begin
        power_q <= pwdata[ACS_POS_POWER];
        pattern_q <= pwdata[ACS_POS_PATTERN +: 2];
        multi_q <= pwdata[ACS_POS_MULTI];
        loop_q <= pwdata[ACS_POS_LOOP];
      end else if (paddr == ACS_OFF_REF_BUF) begin
        ref_q <= pwdata[ACS_POS_REF +: 2];
        buf_en_q <= pwdata[ACS_POS_BUF_EN];
      end else if (paddr == ACS_OFF_CHAN_SEL) begin
        chan_q <= pwdata[7:0];
      end
    end
  end

  // ***********************************************************
  // Trigger synchroniser and edge detect
  // ***********************************************************
  // Stage 1 feeds only stage 2; the edge uses stages 2 and 3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
    end else begin
      trig_s1_q <= trigger_in;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end
  assign trig_rise = trig_s2_q & ~trig_s3_q;

  // ***********************************************************
  // Step decode
  // ***********************************************************
  always_comb begin
    dual = 1'b0;
    grp_a = step_q;
    grp_b = step_q;
    n_steps = 2'd0;
    if (!multi_q) begin
      grp_a = pattern_q;
      grp_b = pattern_q;
    end else begin
      case (pattern_q)
        2'b00: begin
          n_steps = 2'd1;
        end
        2'b01: begin
          n_steps = 2'd3;
        end
        2'b10: begin
          dual = 1'b1;
          grp_a = 2'd0;
          grp_b = 2'd1;
        end
        default: begin
          dual = 1'b1;
          n_steps = 2'd1;
          grp_a = {step_q[0], 1'b0};
          grp_b = {step_q[0], 1'b1};
        end
      endcase
    end
  end
  assign last_step = step_q == n_steps;

  // ***********************************************************
  // Sequencer
  // ***********************************************************
  // Pattern changes mid-set take effect at the next step; software should
  // only reconfigure while the start bit is clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_OFF;
      step_q <= 2'd0;
      warm_q <= 16'h0000;
      conv_start <= 1'b0;
      conv_req <= '0;
    end else begin
      conv_start <= 1'b0;
      case (state_q)
        ST_OFF: begin
          warm_q <= 16'h0000;
          if (power_q) begin
            state_q <= ST_WARM;
          end
        end
        ST_WARM: begin
          // Power-up delay before the core may sample
          warm_q <= warm_q + 16'h0001;
          if (!power_q) begin
            state_q <= ST_OFF;
          end else if (warm_q >= 16'(POWERUP_CYC - 1)) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          step_q <= 2'd0;
          if (!power_q) begin
            state_q <= ST_OFF;
          end else if (start_q) begin
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          conv_start <= 1'b1;
          conv_req <= '{dual: dual, group_a: grp_a, group_b: grp_b, chan_sel: chan_q, ref_sel: ref_q};
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (!power_q) begin
            state_q <= ST_OFF;
          end else if (conv_rsp.done) begin
            if (!last_step) begin
              step_q <= step_q + 2'd1;
              state_q <= ST_ISSUE;
            end else begin
              step_q <= 2'd0;
              // Loop restarts while start stays set
              state_q <= (loop_q && start_q) ? ST_ISSUE : ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_OFF;
        end
      endcase
    end
  end

  // Start / completion bit: a start request wins over hardware completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
    end else if (sw_start) begin
      // The power bit in the same write decides, so power-up and start may share one write
      start_q <= pwdata[ACS_POS_POWER];
    end else if (!power_q) begin
      start_q <= 1'b0;
    end else if (trig_rise) begin
      start_q <= 1'b1;
    end else if (sw_stop) begin
      start_q <= 1'b0;
    end else if (state_q == ST_WAIT && conv_rsp.done && last_step && !loop_q) begin
      start_q <= 1'b0;
    end
  end

  // ***********************************************************
  // Result buffer
  // ***********************************************************
  // With the buffer off the first result lands in location 0; the second result of a pair is dropped
  assign push_a = state_q == ST_WAIT && conv_rsp.done;
  assign push_b = push_a && conv_req.dual;
  assign wptr_b = buf_en_q ? wptr_q + 2'd1 : 2'd0;

  // Write pointer advances circularly by one or two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= 2'd0;
    end else if (!buf_en_q) begin
      wptr_q <= 2'd0;
    end else if (push_a) begin
      wptr_q <= wptr_q + (push_b ? 2'd2 : 2'd1);
    end
  end

  // Read pointer advances on each result read while the buffer is enabled; held at 0 when off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rptr_q <= 2'd0;
    end else if (!buf_en_q) begin
      rptr_q <= 2'd0;
    end else if (pop) begin
      rptr_q <= rptr_q + 2'd1;
    end
  end

  // One storage word and unread flag per location
  for (genvar i = 0; i < ACS_BUF_DEPTH; i++) begin : g_loc
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        buf_q[i] <= '0;
        unread_q[i] <= 1'b0;
      end else begin
        if (push_a && 2'(i) == wptr_q) begin
          buf_q[i] <= conv_rsp.res_a;
        end else if (push_b && 2'(i) == wptr_b) begin
          buf_q[i] <= conv_rsp.res_b;
        end
        // A write in the same cycle as the read wins
        if ((push_a && 2'(i) == wptr_q) || (push_b && 2'(i) == wptr_b)) begin
          unread_q[i] <= 1'b1;
        end else if (pop && 2'(i) == rptr_q) begin
          unread_q[i] <= 1'b0;
        end
      end
    end
  end

  // Overrun is sticky until the buffer is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun_q <= 1'b0;
    end else if ((push_a && unread_q[wptr_q] && !(pop && rptr_q == wptr_q)) ||
                 (push_b && unread_q[wptr_b] && !(pop && rptr_q == wptr_b))) begin
      overrun_q <= 1'b1;
    end else if (!buf_en_q) begin
      overrun_q <= 1'b0;
    end
  end

  // Power output to the analog core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_power_on <= 1'b0;
    end else begin
      converter_power_on <= power_q;
    end
  end

endmodule
`default_nettype wire

//--- testbench/acs_sequencer_props.sv
// Checker: port-level properties of the conversion sequencer
`default_nettype none
module acs_sequencer_props #(
  parameter int POWERUP_CYC = acs_pkg::ACS_POWERUP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire acs_pkg::acs_conv_req_type conv_req,
  input wire logic conv_start,
  input wire logic converter_power_on
);
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  logic [15:0] pw_cnt_q; // Cycles since the converter was powered
  // Saturating count of powered cycles, cleared while off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pw_cnt_q <= 16'h0000;
    end else if (!converter_power_on) begin
      pw_cnt_q <= 16'h0000;
    end else if (pw_cnt_q != 16'hFFFF) begin
      pw_cnt_q <= pw_cnt_q + 16'h0001;
    end
  end
  // ****************************************
  // Bus and core-link properties
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_zero_wait;
    s_setup |=> s_access;
  endproperty
  property p_err_ready;
    pslverr |-> s_access;
  endproperty
  property p_unmapped;
    (psel && !penable && paddr > ACS_OFF_RESULT) |=> pslverr;
  endproperty
  property p_err_zero;
    (pslverr && !pwrite) |-> prdata == 32'h00000000;
  endproperty
  property p_seq_unused;
    s_access ##0 (!pwrite && paddr == ACS_OFF_SEQ_CTRL) |-> prdata[31:6] == 26'h0;
  endproperty
  property p_buf_unused;
    s_access ##0 (!pwrite && paddr == ACS_OFF_REF_BUF) |-> prdata[31:8] == 24'h0 && !prdata[5];
  endproperty
  property p_res_width;
    s_access ##0 (!pwrite && paddr == ACS_OFF_RESULT) |-> prdata[31:10] == 22'h0;
  endproperty
  property p_start_pulse;
    conv_start |=> !conv_start;
  endproperty
  property p_warmup;
    conv_start |-> converter_power_on && pw_cnt_q >= POWERUP_CYC - 1;
  endproperty
  property p_req_hold;
    !conv_start |-> $stable(conv_req);
  endproperty
  property p_dual_pair;
    (conv_start && conv_req.dual) |-> conv_req.group_b == conv_req.group_a + 2'h1 && !conv_req.group_a[0];
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("no answer in first access cycle");
  a_err_ready: assert property (p_err_ready) else $error("error flag outside access");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_err_zero: assert property (p_err_zero) else $error("refused read data not zero");
  a_seq_unused: assert property (p_seq_unused) else $error("unused control bits set");
  a_buf_unused: assert property (p_buf_unused) else $error("unused status bits set");
  a_res_width: assert property (p_res_width) else $error("result wider than ten bits");
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  a_warmup: assert property (p_warmup) else $error("sampling before power-up delay");
  a_req_hold: assert property (p_req_hold) else $error("request changed without start");
  a_dual_pair: assert property (p_dual_pair) else $error("bad simultaneous pair");
endmodule
bind acs_sequencer acs_sequencer_props #(.POWERUP_CYC(POWERUP_CYC)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_req(conv_req), .conv_start(conv_start),
  .converter_power_on(converter_power_on)
);
`default_nettype wire

//--- testbench/acs_core_model.sv
// Partner: sample-and-hold and conversion core model
`default_nettype none
module acs_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] lat,
  input wire acs_pkg::acs_conv_req_type conv_req,
  input wire logic conv_start,
  output acs_pkg::acs_conv_rsp_type conv_rsp,
  output logic [7:0] start_count
);
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  acs_conv_req_type req_q; // Request held while converting
  logic busy_q; // Conversion in progress
  logic [3:0] wait_q; // Cycles left before the answer
  // Result code tells group, channel, reference and pairing apart
  function automatic logic [9:0] code(input logic [1:0] g, input acs_conv_req_type r);
    return {g, r.chan_sel[2*g+:2], r.ref_sel, r.dual, 3'h5};
  endfunction
  // Answer each start after a latency chosen by the bench
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_rsp <= '0;
      req_q <= '0;
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      start_count <= 8'h00;
    end else begin
      conv_rsp.done <= 1'b0;
      // Result lines flip outside answers so stale data is never taken
      conv_rsp.res_a <= ~conv_rsp.res_a;
      conv_rsp.res_b <= ~conv_rsp.res_b;
      if (conv_start) begin
        req_q <= conv_req;
        busy_q <= 1'b1;
        wait_q <= lat;
        start_count <= start_count + 8'h01;
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
        conv_rsp.done <= 1'b1;
        conv_rsp.res_a <= code(req_q.group_a, req_q);
        conv_rsp.res_b <= code(req_q.group_b, req_q);
        busy_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Testbench: register, sequencing and buffer scenarios
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import acs_pkg::*;
  localparam int PUC = 4; // Shortened power-up wait
  localparam logic [7:0] CHAN = 8'hE4; // Distinct channel per group
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, trigger_in, conv_start, converter_power_on, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb, lat;
  logic [7:0] start_count, n0;
  logic [9:0] q[$];
  acs_conv_req_type conv_req;
  acs_conv_rsp_type conv_rsp;
  int num_errors, check_count, ptr;
  int cycles = 0;
  acs_sequencer #(.POWERUP_CYC(PUC)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_in(trigger_in), .conv_req(conv_req), .conv_start(conv_start),
    .conv_rsp(conv_rsp), .converter_power_on(converter_power_on));
  acs_core_model u_core (.pclk(pclk), .presetn(presetn), .lat(lat), .conv_req(conv_req),
    .conv_start(conv_start), .conv_rsp(conv_rsp), .start_count(start_count));
  // ****************************************
  // Clock, timeout and tasks
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Hang guard, far above the expected run length
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask
  // One APB transfer; request held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    check(name, exp, rdat);
  endtask
  // Poll until the start bit drops, bounded
  task automatic idle();
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, ACS_OFF_SEQ_CTRL, 32'h0);
      if (rdat[1] === 1'b0) break;
    end
    check("start_cleared", 32'h0, {31'h0, rdat[1]});
  endtask
  function automatic logic [9:0] ex(input int g, input logic dual);
    return {g[1:0], CHAN[2*g+:2], 2'h3, dual, 3'h5};
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, trigger_in, presetn} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    lat = 4'h2;
    num_errors = 0;
    check_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(ACS_OFF_SEQ_CTRL, 32'h0, "seq_reset");
    rd(ACS_OFF_REF_BUF, 32'h08, "buf_reset");
    rd(ACS_OFF_CHAN_SEL, 32'h0, "chan_reset");
    $display("test reset done");
    apb(1'b1, ACS_OFF_SEQ_CTRL, 32'hFC);
    rd(ACS_OFF_SEQ_CTRL, 32'h3C, "seq_bits");
    apb(1'b1, ACS_OFF_SEQ_CTRL, 32'h0);
    apb(1'b1, ACS_OFF_REF_BUF, 32'hFF);
    rd(ACS_OFF_REF_BUF, 32'hD8, "buf_bits");
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b1, ACS_OFF_CHAN_SEL, {24'h0, CHAN});
    rd(ACS_OFF_CHAN_SEL, {24'h0, CHAN}, "chan_rw");
    pstrb <= 4'h0;
    apb(1'b1, ACS_OFF_CHAN_SEL, 32'hFF);
    pstrb <= 4'hF;
    rd(ACS_OFF_CHAN_SEL, {24'h0, CHAN}, "chan_strb_off");
    $display("test fields done");
    // Every mode: single groups, then the four multi patterns
    ptr = 0;
    for (int m = 0; m < 8; m++) begin
      q.delete();
      if (!m[2]) q.push_back(ex(m % 4, 1'b0));
      else case (m % 4)
        0: q = '{ex(0, 1'b0), ex(1, 1'b0)};
        1: q = '{ex(0, 1'b0), ex(1, 1'b0), ex(2, 1'b0), ex(3, 1'b0)};
        2: q = '{ex(0, 1'b1), ex(1, 1'b1)};
        default: q = '{ex(0, 1'b1), ex(1, 1'b1), ex(2, 1'b1), ex(3, 1'b1)};
      endcase
      apb(1'b1, ACS_OFF_SEQ_CTRL, {27'h0, m[2], m[1:0], 2'h3});
      idle();
      rd(ACS_OFF_REF_BUF, 32'hD0 + 32'(ptr), "status_full");
      foreach (q[i]) begin
        rd(ACS_OFF_RESULT, {22'h0, q[i]}, "result");
        ptr = (ptr + 1) % 4;
      end
      rd(ACS_OFF_REF_BUF, 32'hD8 + 32'(ptr), "status_empty");
    end
    $display("test modes done");
    // Five unread results in four words
    apb(1'b1, ACS_OFF_SEQ_CTRL, 32'h17);
    idle();
    apb(1'b1, ACS_OFF_SEQ_CTRL, 32'h03);
    idle();
    rd(ACS_OFF_REF_BUF, 32'hD4, "overrun_set");
    apb(1'b1, ACS_OFF_REF_BUF, 32'hC0);
    apb(1'b0, ACS_OFF_REF_BUF, 32'h0);
    check("overrun_clear", 32'h0, rdat & 32'h14);
    $display("test overrun done");
    // Continuous loop with a slow core
    lat <= 4'h9;
    n0 = start_count;
    apb(1'b1, ACS_OFF_SEQ_CTRL, 32'h23);
    repeat (60) @(posedge pclk);
    rd(ACS_OFF_SEQ_CTRL, 32'h23, "loop_held");
    check("loop_repeats", 32'h1, {31'h0, start_count >= n0 + 8'h02});
    apb(1'b1, ACS_OFF_SEQ_CTRL, 32'h21);
    repeat (20) @(posedge pclk);
    n0 = start_count;
    repeat (40) @(posedge pclk);
    check("loop_stopped", {24'h0, n0}, {24'h0, start_count});
    rd(ACS_OFF_SEQ_CTRL, 32'h21, "loop_stop_bit");
    $display("test loop done");
    // Trigger start of a single group B conversion
    apb(1'b1, ACS_OFF_SEQ_CTRL, 32'h05);
    n0 = start_count;
    trigger_in <= 1'b1;
    for (int k = 0; k < 50 && start_count === n0; k++) @(posedge pclk);
    check("trigger_start", {24'h0, n0 + 8'h01}, {24'h0, start_count});
    idle();
    rd(ACS_OFF_RESULT, {22'h0, ex(1, 1'b0)}, "trigger_result");
    trigger_in <= 1'b0;
    $display("test trigger done");
    results();
  end
endmodule
`default_nettype wire
